// ===== hdl/rssi_pkg.sv
// Purpose: Shared constants and types for the dual-range signal-strength conversion control.
// Assumes: Byte-wide register port; multi-byte registers hold the high byte at the even address.
// Notes:   Index order for per-channel tables is [channel][range], range 0 fine and 1 coarse.
package rssi_pkg;

	localparam logic [7:0] ADDR_RESULT_CH1  = 8'h68;
	localparam logic [7:0] ADDR_RESULT_CH2  = 8'h6A;
	localparam logic [7:0] ADDR_RANGE_FLAGS = 8'h6F;
	localparam logic [7:0] ADDR_OVERRIDE    = 8'h8D;
	localparam logic [7:0] ADDR_SHIFT_CH1   = 8'h8E;
	localparam logic [7:0] ADDR_SHIFT_CH2   = 8'h8F;

	// Base (even) byte addresses, [channel][range].
	localparam logic [1:0][1:0][7:0] ADDR_GAIN   = {8'h98, 8'h9A, 8'h9C, 8'h9E};
	localparam logic [1:0][1:0][7:0] ADDR_OFFSET = {8'hA8, 8'hAA, 8'hAC, 8'hAE};
	localparam logic [1:0][1:0][7:0] ADDR_XOVER  = {8'h94, 8'h96, 8'hA4, 8'hA6};

	// Field positions in the override register: bit a, bit b and crossover enable per channel.
	localparam int unsigned OVR_A_POS   = 0;
	localparam int unsigned OVR_B_POS   = 1;
	localparam int unsigned OVR_STRIDE  = 2;
	localparam int unsigned XOVER_EN_POS = 4;

	localparam logic [7:0]  OVERRIDE_RST     = 8'h00;
	localparam logic [2:0]  SHIFT_RST        = 3'h0;
	localparam logic [15:0] GAIN_RST         = 16'h8000;
	localparam logic [15:0] OFFSET_RST       = 16'h0000;
	localparam logic [15:0] XOVER_FINE_RST   = 16'hFFFF;
	localparam logic [15:0] XOVER_COARSE_RST = 16'h0000;
	localparam logic [15:0] RESULT_RST       = 16'h0000;
	localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

	// Hysteresis limits indexed by shift count, element 0 at the right.
	localparam logic [7:0][15:0] HYST_FINE_MAX = {
		16'h01FF, 16'h03FF, 16'h07FF, 16'h0FFF, 16'h1FFF, 16'h3FFE, 16'h7FFC, 16'hFFF8};
	localparam logic [7:0][15:0] HYST_COARSE_MIN = {
		16'h01E0, 16'h03C0, 16'h0780, 16'h0F00, 16'h1E00, 16'h3C00, 16'h7800, 16'hF000};

	typedef enum logic [1:0] {MODE_DUAL, MODE_FINE_ONLY, MODE_FORCE_COARSE, MODE_FORCE_FINE} range_mode_e;

	typedef enum logic [1:0] {ST_IDLE, ST_FINE, ST_COARSE} seq_e;

	typedef struct packed {
		logic        chan;
		logic        coarse;
		logic [15:0] gain;
		logic [15:0] offset;
	} adc_cmd_s;

	typedef struct packed {
		logic        chan;
		logic        coarse;
		logic [15:0] value;
	} meas_s;

	typedef struct packed {
		logic [7:0]             override;
		logic [1:0][2:0]        shift;
		logic [1:0][1:0][15:0]  gain;
		logic [1:0][1:0][15:0]  offset;
		logic [1:0][1:0][15:0]  xover;
	} cfg_s;

endpackage

// ===== hdl/rssi_result_shaper.sv
// Purpose: Range decision, coarse floor and right-shift for one channel's raw conversion.
// Assumes: Raw result is already gain and offset corrected by the converter.
// Notes:   Purely combinational; one copy per channel.
module rssi_result_shaper
	import rssi_pkg::*;
(
	input  wire logic [15:0] raw_i,
	input  wire logic        coarse_i,
	input  wire logic [2:0]  shift_i,
	input  wire logic        xover_en_i,
	input  wire logic [15:0] fine_xover_i,
	input  wire logic [15:0] coarse_xover_i,
	output logic             too_large_o,
	output logic [15:0]      value_o
);
	logic [15:0] fine_limit;
	logic [15:0] coarse_floor;
	logic [15:0] floored;

	always_comb
	begin
		// Limits come from the crossover registers or from the shift-indexed hysteresis table.
		fine_limit   = xover_en_i ? fine_xover_i : HYST_FINE_MAX[shift_i];
		coarse_floor = xover_en_i ? coarse_xover_i : HYST_COARSE_MIN[shift_i];
		too_large_o  = raw_i > fine_limit;
		floored      = (coarse_i && raw_i < coarse_floor) ? coarse_floor : raw_i;
		value_o      = floored >> shift_i;
	end
endmodule

// ===== hdl/rssi_dual_range_adc_control.sv
// Purpose: Sequences fine and coarse conversions for two signal-strength channels and holds their registers.
// Assumes: The shared converter answers each request with one adc_done_i pulse carrying adc_raw_i.
// Notes:   Slice starts that arrive while a slice is in progress are ignored.
//Contract
//- Each channel has its own 3-bit right-shift count in configuration.
//- Results are shifted zero to seven places before alarm compare and storage.
//- The shift applies equally during calibration setup; there is no bypass.
//- Both override bits reset to zero, so dual-range operation is the default.
//- Override bits a=0, b=1 disable dual-range operation for that channel.
//- Both override bits of each channel sit in one writable register.
//- Override bits can force every conversion into fine or coarse mode.
//- Every slice starts with a fine conversion using fine settings; forced-coarse slices here start with a coarse one.
//- A fine result too large triggers a coarse conversion, reported instead.
//- Coarse conversions use the same shift but separate gain and offset.
//- Fine and coarse results land in the same measurement register pair.
//- A range indicator bit shows which range produced the stored result.
//- With crossover enabled, fine crossover sets the largest unshifted fine result.
//- With crossover enabled, coarse crossover sets the smallest unshifted coarse result.
//- Crossover mode gives independent shift, gain and offset per range; here the shift is one per channel, shared by both ranges.
//- Crossover disabled uses hysteresis thresholds depending only on shift count.
//- Crossover disabled auto-selects the finer range, fine scale being coarse over 2^n.
//- Hysteresis limits for shifts 0 to 3: FFF8/F000, 7FFC/7800, 3FFE/3C00, 1FFF/1E00.
//- Hysteresis limits for shifts 4 to 7: 0FFF/0F00 down to 01FF/01E0.
module rssi_dual_range_adc_control
	import rssi_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              reset_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_wdata_i,
	output logic      [7:0]        reg_rdata_o,
	input  wire logic              slice_start_i,
	input  wire logic              slice_chan_i,
	output logic                   adc_req_o,
	output rssi_pkg::adc_cmd_s     adc_cmd_o,
	input  wire logic              adc_done_i,
	input  wire logic [15:0]       adc_raw_i,
	output logic                   meas_valid_o,
	output rssi_pkg::meas_s        meas_o,
	output logic                   busy_o
);
	import rssi_pkg::*;

	typedef struct packed {
		seq_e             st;
		cfg_s             cfg;
		logic             req;
		adc_cmd_s         cmd;
		logic [1:0][15:0] result;
		logic [1:0]       range_ind;
		logic [7:0]       rdata;
		logic             mvalid;
		meas_s            meas;
		logic             busy;
	} state_s;

	state_s q;
	state_s d;

	logic [1:0]        too_large;
	logic [1:0][15:0]  shaped;
	range_mode_e [1:0] mode;
	range_mode_e       start_mode;
	range_mode_e       cur_mode;
	logic [7:0]        base_addr;
	logic              hi_byte;

	// Decode the two override bits of each channel into a range mode.
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			case ({q.cfg.override[c * OVR_STRIDE + OVR_A_POS], q.cfg.override[c * OVR_STRIDE + OVR_B_POS]})
				2'b00: mode[c] = MODE_DUAL;
				2'b01: mode[c] = MODE_FINE_ONLY;
				2'b10: mode[c] = MODE_FORCE_COARSE;
				2'b11: mode[c] = MODE_FORCE_FINE;
				default: mode[c] = MODE_DUAL;
			endcase
		end
		start_mode = mode[slice_chan_i];
		cur_mode   = mode[q.cmd.chan];
	end

	// One shaper per channel keeps each channel's limits and shift independent.
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_shape
			rssi_result_shaper u_shaper (
				.raw_i          (adc_raw_i),
				.coarse_i       (q.cmd.coarse),
				.shift_i        (q.cfg.shift[g]),
				.xover_en_i     (q.cfg.override[XOVER_EN_POS + g]),
				.fine_xover_i   (q.cfg.xover[g][0]),
				.coarse_xover_i (q.cfg.xover[g][1]),
				.too_large_o    (too_large[g]),
				.value_o        (shaped[g])
			);
		end
	endgenerate

	always_comb
	begin
		d         = q;
		d.req     = 1'b0;
		d.mvalid  = 1'b0;
		base_addr = {reg_addr_i[7:1], 1'b0};
		hi_byte   = ~reg_addr_i[0];

		// Register writes; the high byte of a 16-bit register sits at the even address.
		if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_OVERRIDE)
				d.cfg.override = reg_wdata_i;
			if (reg_addr_i == ADDR_SHIFT_CH1)
				d.cfg.shift[0] = reg_wdata_i[2:0];
			if (reg_addr_i == ADDR_SHIFT_CH2)
				d.cfg.shift[1] = reg_wdata_i[2:0];
			for (int c = 0; c < 2; c++)
			begin
				for (int r = 0; r < 2; r++)
				begin
					if (base_addr == ADDR_GAIN[c][r])
					begin
						if (hi_byte)
							d.cfg.gain[c][r][15:8] = reg_wdata_i;
						else
							d.cfg.gain[c][r][7:0] = reg_wdata_i;
					end
					if (base_addr == ADDR_OFFSET[c][r])
					begin
						if (hi_byte)
							d.cfg.offset[c][r][15:8] = reg_wdata_i;
						else
							d.cfg.offset[c][r][7:0] = reg_wdata_i;
					end
					if (base_addr == ADDR_XOVER[c][r])
					begin
						if (hi_byte)
							d.cfg.xover[c][r][15:8] = reg_wdata_i;
						else
							d.cfg.xover[c][r][7:0] = reg_wdata_i;
					end
				end
			end
		end

		// Register reads answer one edge later and hold until the next read.
		if (reg_rd_i)
		begin
			d.rdata = UNMAPPED_READ;
			if (base_addr == ADDR_RESULT_CH1)
				d.rdata = hi_byte ? q.result[0][15:8] : q.result[0][7:0];
			if (base_addr == ADDR_RESULT_CH2)
				d.rdata = hi_byte ? q.result[1][15:8] : q.result[1][7:0];
			if (reg_addr_i == ADDR_RANGE_FLAGS)
				d.rdata = {6'h00, q.range_ind};
			if (reg_addr_i == ADDR_OVERRIDE)
				d.rdata = q.cfg.override;
			if (reg_addr_i == ADDR_SHIFT_CH1)
				d.rdata = {5'h00, q.cfg.shift[0]};
			if (reg_addr_i == ADDR_SHIFT_CH2)
				d.rdata = {5'h00, q.cfg.shift[1]};
			for (int c = 0; c < 2; c++)
			begin
				for (int r = 0; r < 2; r++)
				begin
					if (base_addr == ADDR_GAIN[c][r])
						d.rdata = hi_byte ? q.cfg.gain[c][r][15:8] : q.cfg.gain[c][r][7:0];
					if (base_addr == ADDR_OFFSET[c][r])
						d.rdata = hi_byte ? q.cfg.offset[c][r][15:8] : q.cfg.offset[c][r][7:0];
					if (base_addr == ADDR_XOVER[c][r])
						d.rdata = hi_byte ? q.cfg.xover[c][r][15:8] : q.cfg.xover[c][r][7:0];
				end
			end
		end

		case (q.st)
			ST_IDLE:
			begin
				if (slice_start_i)
				begin
					d.req       = 1'b1;
					d.cmd.chan  = slice_chan_i;
					if (start_mode == MODE_FORCE_COARSE)
					begin
						d.st         = ST_COARSE;
						d.cmd.coarse = 1'b1;
						d.cmd.gain   = q.cfg.gain[slice_chan_i][1];
						d.cmd.offset = q.cfg.offset[slice_chan_i][1];
					end
					else
					begin
						d.st         = ST_FINE;
						d.cmd.coarse = 1'b0;
						d.cmd.gain   = q.cfg.gain[slice_chan_i][0];
						d.cmd.offset = q.cfg.offset[slice_chan_i][0];
					end
				end
			end
			ST_FINE:
			begin
				if (adc_done_i)
				begin
					// Only dual-range operation may fall back; forced or disabled modes keep the fine answer.
					if (cur_mode == MODE_DUAL && too_large[q.cmd.chan])
					begin
						d.st         = ST_COARSE;
						d.req        = 1'b1;
						d.cmd.coarse = 1'b1;
						d.cmd.gain   = q.cfg.gain[q.cmd.chan][1];
						d.cmd.offset = q.cfg.offset[q.cmd.chan][1];
					end
					else
					begin
						d.st                   = ST_IDLE;
						d.result[q.cmd.chan]    = shaped[q.cmd.chan];
						d.range_ind[q.cmd.chan] = 1'b0;
						d.mvalid               = 1'b1;
						d.meas                 = '{chan: q.cmd.chan, coarse: 1'b0, value: shaped[q.cmd.chan]};
					end
				end
			end
			ST_COARSE:
			begin
				if (adc_done_i)
				begin
					d.st                   = ST_IDLE;
					d.result[q.cmd.chan]    = shaped[q.cmd.chan];
					d.range_ind[q.cmd.chan] = 1'b1;
					d.mvalid               = 1'b1;
					d.meas                 = '{chan: q.cmd.chan, coarse: 1'b1, value: shaped[q.cmd.chan]};
				end
			end
			default:
				d.st = ST_IDLE;
		endcase
		d.busy = (d.st != ST_IDLE);
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			q.st           <= ST_IDLE;
			q.cfg.override <= OVERRIDE_RST;
			q.cfg.shift    <= {2{SHIFT_RST}};
			q.cfg.gain     <= {4{GAIN_RST}};
			q.cfg.offset   <= {4{OFFSET_RST}};
			q.cfg.xover    <= {2{XOVER_COARSE_RST, XOVER_FINE_RST}};
			q.req          <= 1'b0;
			q.cmd          <= '0;
			q.result       <= {2{RESULT_RST}};
			q.range_ind    <= 2'b00;
			q.rdata        <= UNMAPPED_READ;
			q.mvalid       <= 1'b0;
			q.meas         <= '0;
			q.busy         <= 1'b0;
		end
		else
		begin
			q <= d;
		end
	end

	assign reg_rdata_o  = q.rdata;
	assign adc_req_o    = q.req;
	assign adc_cmd_o    = q.cmd;
	assign meas_valid_o = q.mvalid;
	assign meas_o       = q.meas;
	assign busy_o       = q.busy;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	override_default_a: assert property ($fell(reset_i) |-> q.cfg.override == OVERRIDE_RST)
		else $error("Override bits not zero after reset.");

	override_write_a: assert property (reg_wr_i && reg_addr_i == ADDR_OVERRIDE
		|=> q.cfg.override == $past(reg_wdata_i))
		else $error("Override register write lost.");

	slice_fine_first_a: assert property (q.st == ST_IDLE && slice_start_i
		&& start_mode != MODE_FORCE_COARSE
		|=> adc_req_o && !adc_cmd_o.coarse && adc_cmd_o.gain == q.cfg.gain[adc_cmd_o.chan][0])
		else $error("Slice did not start with a fine request.");

	forced_coarse_a: assert property (q.st == ST_IDLE && slice_start_i
		&& start_mode == MODE_FORCE_COARSE |=> adc_req_o && adc_cmd_o.coarse)
		else $error("Forced coarse slice issued a fine request.");

	coarse_fallback_a: assert property (q.st == ST_FINE && adc_done_i && cur_mode == MODE_DUAL
		&& too_large[q.cmd.chan] |=> adc_req_o && adc_cmd_o.coarse && !meas_valid_o)
		else $error("Oversized fine result did not fall back to coarse.");

	disabled_no_coarse_a: assert property (q.st == ST_FINE && adc_done_i && cur_mode == MODE_FINE_ONLY
		|=> !adc_req_o && meas_valid_o && !meas_o.coarse)
		else $error("Disabled dual range still converted coarse.");

	fine_shift_a: assert property (q.st == ST_FINE && adc_done_i
		&& !(cur_mode == MODE_DUAL && too_large[q.cmd.chan])
		|=> meas_o.value == ($past(adc_raw_i) >> $past(q.cfg.shift[q.cmd.chan])))
		else $error("Stored fine result not shifted by the channel count.");

	range_flag_a: assert property (meas_valid_o |-> q.range_ind[meas_o.chan] == meas_o.coarse
		&& q.result[meas_o.chan] == meas_o.value)
		else $error("Range indicator or stored result disagrees with the report.");

	req_one_cycle_a: assert property (adc_req_o |=> !adc_req_o ##1 (busy_o || meas_valid_o))
		else $error("Converter request held longer than one cycle.");

	// The fallback and floor checks below restate the range decision from the registers, so a broken shaper cannot hide.
	busy_start_a: assert property (q.st == ST_IDLE && slice_start_i |=> busy_o && adc_req_o)
		else $error("Slice start did not raise busy with a request.");

	xover_fallback_a: assert property (q.st == ST_FINE && adc_done_i && cur_mode == MODE_DUAL
		&& q.cfg.override[XOVER_EN_POS + q.cmd.chan] && adc_raw_i > q.cfg.xover[q.cmd.chan][0]
		|=> adc_req_o && adc_cmd_o.coarse)
		else $error("Fine result above the crossover limit stayed fine.");

	hyst_fallback_a: assert property (q.st == ST_FINE && adc_done_i && cur_mode == MODE_DUAL
		&& !q.cfg.override[XOVER_EN_POS + q.cmd.chan]
		&& adc_raw_i > HYST_FINE_MAX[q.cfg.shift[q.cmd.chan]] |=> adc_req_o && adc_cmd_o.coarse)
		else $error("Fine result above the hysteresis maximum stayed fine.");

	hyst_fine_keep_a: assert property (q.st == ST_FINE && adc_done_i && cur_mode == MODE_DUAL
		&& !q.cfg.override[XOVER_EN_POS + q.cmd.chan]
		&& adc_raw_i <= HYST_FINE_MAX[q.cfg.shift[q.cmd.chan]] |=> meas_valid_o && !meas_o.coarse)
		else $error("Fine result within the hysteresis maximum went coarse.");

	coarse_floor_a: assert property (q.st == ST_COARSE && adc_done_i
		&& !q.cfg.override[XOVER_EN_POS + q.cmd.chan]
		&& adc_raw_i < HYST_COARSE_MIN[q.cfg.shift[q.cmd.chan]]
		|=> meas_o.value == ($past(HYST_COARSE_MIN[q.cfg.shift[q.cmd.chan]]) >> $past(q.cfg.shift[q.cmd.chan])))
		else $error("Coarse result below the floor was not raised to it.");

	coarse_flag_a: assert property (q.st == ST_COARSE && adc_done_i
		|=> meas_valid_o && meas_o.coarse && q.range_ind[meas_o.chan])
		else $error("Coarse result not flagged as coarse.");

	meas_pulse_a: assert property (meas_valid_o |=> !meas_valid_o)
		else $error("Result strobe held longer than one cycle.");
endmodule

// ===== verif/adc_model.sv
// Purpose: Behavioural shared converter that answers each conversion request once.
// Assumes: One request outstanding at a time; the bench sets latency and raw values.
// Notes:   Between answers the raw bus toggles every cycle, so stale data is never trusted.
module adc_model
	import rssi_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic         req_i,
	input  rssi_pkg::adc_cmd_s cmd_i,
	input  wire logic [15:0]  fine_raw_i,
	input  wire logic [15:0]  coarse_raw_i,
	input  wire logic [2:0]   lat_i,
	output logic              done_o,
	output logic [15:0]       raw_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       pend_q;
	logic       coarse_q;
	logic [2:0] cnt_q;

	// The answer comes at least one cycle after the request is seen.
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pend_q   <= 1'b0;
			coarse_q <= 1'b0;
			cnt_q    <= 3'h0;
			done_o   <= 1'b0;
			raw_o    <= 16'h0000;
		end
		else
		begin
			done_o <= 1'b0;
			raw_o  <= ~raw_o;
			if (req_i)
			begin
				pend_q   <= 1'b1;
				coarse_q <= cmd_i.coarse;
				cnt_q    <= lat_i;
			end
			else if (pend_q && cnt_q == 3'h0)
			begin
				pend_q <= 1'b0;
				done_o <= 1'b1;
				raw_o  <= coarse_q ? coarse_raw_i : fine_raw_i;
			end
			else if (pend_q)
				cnt_q <= cnt_q - 3'h1;
		end
	end
endmodule

// ===== verif/tb.sv
// Purpose: Self-checking bench for the dual-range signal-strength conversion control.
// Assumes: Register and slice timing as handed over; converter latency drawn at random.
// Notes:   Sweeps every override code, both crossover modes and both channels with limit corners.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rssi_pkg::*;
	logic                  sys_clk = 1'b0;
	logic                  reset = 1'b1;
	logic [7:0]            reg_addr = 8'h00;
	logic                  reg_wr = 1'b0;
	logic                  reg_rd = 1'b0;
	logic [7:0]            reg_wdata = 8'h00;
	logic [7:0]            reg_rdata;
	logic                  slice_start = 1'b0;
	logic                  slice_chan = 1'b0;
	logic                  adc_req;
	adc_cmd_s              adc_cmd;
	logic                  adc_done;
	logic [15:0]           adc_raw;
	logic                  meas_valid;
	meas_s                 meas;
	logic                  busy;
	logic [15:0]           fine_raw = 16'h0000;
	logic [15:0]           coarse_raw = 16'h0000;
	logic [2:0]            lat = 3'h0;
	logic [1:0][1:0][15:0] gtab;
	logic [1:0][1:0][15:0] otab;
	logic [1:0][1:0][15:0] xtab;
	logic [7:0]            ovr;
	logic                  cur_ch;
	logic [1:0]            cur_m;
	int                    nreq;
	int                    errors = 0;
	int                    cmp_count = 0;
	int                    cyc = 0;

	rssi_dual_range_adc_control rssi_dual_range_adc_control_i (.sys_clk_i(sys_clk), .reset_i(reset),
		.reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(reg_rdata), .slice_start_i(slice_start), .slice_chan_i(slice_chan),
		.adc_req_o(adc_req), .adc_cmd_o(adc_cmd), .adc_done_i(adc_done), .adc_raw_i(adc_raw),
		.meas_valid_o(meas_valid), .meas_o(meas), .busy_o(busy));
	adc_model adc_model_i (.sys_clk_i(sys_clk), .reset_i(reset), .req_i(adc_req), .cmd_i(adc_cmd),
		.fine_raw_i(fine_raw), .coarse_raw_i(coarse_raw), .lat_i(lat), .done_o(adc_done), .raw_o(adc_raw));

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic close_out();
		$display("mismatches %0d of %0d comparisons", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			close_out();
		end
	end

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 8'h01, v[7:0]);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask

	function automatic logic [17:0] expect_meas(input logic ch, input logic [1:0] m, input logic xen,
		input logic [2:0] s, input logic [15:0] rf, input logic [15:0] rc);
		logic [15:0] lim;
		logic [15:0] flr;
		logic [15:0] v;
		logic        co;
		lim = xen ? xtab[ch][0] : HYST_FINE_MAX[s];
		flr = xen ? xtab[ch][1] : HYST_COARSE_MIN[s];
		co  = (m == 2'b10) || (m == 2'b00 && rf > lim);
		v   = co ? ((rc < flr) ? flr : rc) : rf;
		return {ch, co, v >> s};
	endfunction

	// Every request is checked against the range it should be in and that range's own settings.
	always @(negedge sys_clk)
	begin
		if (adc_req === 1'b1)
		begin
			chk(adc_cmd, {cur_ch, (cur_m == 2'b10) || nreq == 1, gtab[cur_ch][(cur_m == 2'b10) || nreq == 1],
				otab[cur_ch][(cur_m == 2'b10) || nreq == 1]});
			chk(busy, 1'b1);
			nreq++;
		end
	end

	task automatic slice(input logic ch, input logic [1:0] m, input logic xen, input logic [2:0] s,
		input logic [15:0] rf, input logic [15:0] rc);
		logic [17:0] e;
		logic [7:0]  b;
		int          k;
		e      = expect_meas(ch, m, xen, s, rf, rc);
		cur_ch = ch;
		cur_m  = m;
		nreq   = 0;
		@(posedge sys_clk);
		fine_raw    <= rf;
		coarse_raw  <= rc;
		lat         <= 3'($urandom % 5);
		slice_start <= 1'b1;
		slice_chan  <= ch;
		// A second start while busy must be ignored.
		@(posedge sys_clk);
		slice_chan <= ~ch;
		@(posedge sys_clk);
		slice_start <= 1'b0;
		for (k = 0; k < 40 && meas_valid !== 1'b1; k++)
			@(negedge sys_clk);
		chk(meas, e);
		chk(nreq, (m == 2'b00 && e[16]) ? 2 : 1);
		chk(busy, 1'b0);
		rd(ch ? ADDR_RESULT_CH2 : ADDR_RESULT_CH1, b);
		chk(b, e[15:8]);
		rd((ch ? ADDR_RESULT_CH2 : ADDR_RESULT_CH1) + 8'h01, b);
		chk(b, e[7:0]);
		rd(ADDR_RANGE_FLAGS, b);
		chk(b[ch], e[16]);
	endtask

	initial
	begin
		logic        ch;
		logic [1:0]  m;
		logic        xen;
		logic [2:0]  s;
		logic [15:0] lim;
		logic [15:0] flr;
		logic [15:0] rf;
		logic [15:0] rc;
		logic [7:0]  b;
		void'($urandom(3));
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd(ADDR_OVERRIDE, b);
		chk(b, OVERRIDE_RST);
		rd(ADDR_SHIFT_CH2, b);
		chk(b[2:0], SHIFT_RST);
		rd(8'h00, b);
		chk(b, UNMAPPED_READ);
		xtab = {XOVER_COARSE_RST, XOVER_FINE_RST, XOVER_COARSE_RST, XOVER_FINE_RST};
		ovr  = OVERRIDE_RST;
		for (int c = 0; c < 2; c++)
			for (int r = 0; r < 2; r++)
			begin
				gtab[c][r] = 16'($urandom);
				otab[c][r] = 16'($urandom);
				wr16(ADDR_GAIN[c][r], gtab[c][r]);
				wr16(ADDR_OFFSET[c][r], otab[c][r]);
			end
		rd(ADDR_GAIN[1][1], b);
		chk(b, gtab[1][1][15:8]);
		for (int i = 0; i < 48; i++)
		begin
			ch  = i[3];
			m   = i[1:0];
			xen = i[2];
			s   = 3'($urandom);
			ovr[OVR_STRIDE * ch + OVR_A_POS] = m[1];
			ovr[OVR_STRIDE * ch + OVR_B_POS] = m[0];
			ovr[XOVER_EN_POS + ch] = xen;
			wr(ADDR_OVERRIDE, ovr);
			wr(ch ? ADDR_SHIFT_CH2 : ADDR_SHIFT_CH1, {5'h00, s});
			rd(ADDR_OVERRIDE, b);
			chk(b, ovr);
			if (xen)
			begin
				xtab[ch][0] = 16'($urandom) & 16'hFFFE;
				xtab[ch][1] = 16'($urandom);
				wr16(ADDR_XOVER[ch][0], xtab[ch][0]);
				wr16(ADDR_XOVER[ch][1], xtab[ch][1]);
				rd(ADDR_XOVER[ch][1] + 8'h01, b);
				chk(b, xtab[ch][1][7:0]);
			end
			lim = xen ? xtab[ch][0] : HYST_FINE_MAX[s];
			flr = xen ? xtab[ch][1] : HYST_COARSE_MIN[s];
			case ($urandom % 3)
				0: rf = lim;
				1: rf = lim + 16'h0001;
				default: rf = 16'($urandom);
			endcase
			rc = ($urandom % 2) ? flr - 16'h0001 : 16'($urandom);
			slice(ch, m, xen, s, rf, rc);
		end
		close_out();
	end
endmodule
